//--- core/gfc_pkg.sv
// Purpose: Shared constants for the pin function and compare status block.
// Assumes: 16-bit registers reached at their printed offsets over the register port.
// Notes:   Function and source codes are 4-bit fields of the configuration register.
package gfc_pkg;
    localparam int          NUM_CH             = 4;
    localparam logic [7:0]  ADDR_TRIGGER       = 8'h21;
    localparam logic [7:0]  ADDR_COMPARE_STAT  = 8'h23;
    localparam logic [7:0]  ADDR_PIN_CONFIG    = 8'h24;
    localparam logic [15:0] COMPARE_STAT_RESET = 16'h0000;
    localparam logic [15:0] PIN_CONFIG_RESET   = 16'h0000;
    localparam logic [15:0] PIN_CONFIG_MASK    = 16'hbfff;
    localparam int          STAT_PROTECT_BIT   = 8;
    localparam int          STAT_WIN_LSB       = 4;
    localparam int          STAT_CMP_LSB       = 0;
    localparam int          CFG_FILTER_BIT     = 15;
    localparam int          CFG_OUT_ON_BIT     = 13;
    localparam int          CFG_SRC_LSB        = 9;
    localparam int          CFG_MASK_LSB       = 5;
    localparam int          CFG_FUNC_LSB       = 1;
    localparam int          CFG_IN_ON_BIT      = 0;
    localparam int          TRIG_CLEAR_CH0_BIT = 15;
    localparam int          TRIG_CH_STRIDE     = 4;
    localparam logic [3:0]  SRC_NV_BUSY        = 4'h1;
    localparam logic [1:0]  SRC_GRP_BUSY       = 2'h1;
    localparam logic [1:0]  SRC_GRP_WIN        = 2'h2;
    localparam logic [3:0]  FN_FAULT_SNAPSHOT  = 4'h2;
    localparam logic [3:0]  FN_CURRENT_PDN     = 4'h3;
    localparam logic [3:0]  FN_VOLTAGE_PDN     = 4'h4;
    localparam logic [3:0]  FN_CLEAR           = 4'h7;
    localparam logic [3:0]  FN_LOAD_CODES      = 4'h8;
    localparam logic [3:0]  FN_WAVEFORM        = 4'h9;
    localparam logic [3:0]  FN_MARGIN          = 4'ha;
    localparam logic [3:0]  FN_DEVICE_RESET    = 4'hb;
    localparam logic [3:0]  FN_NV_PROTECT      = 4'hc;
    localparam logic [3:0]  FN_REG_LOCK        = 4'hd;
    localparam int          FILTER_CYCLES      = 4;
    localparam int          FILTER_CNT_W       = 3;
    localparam logic [FILTER_CNT_W-1:0] FILTER_LAST = FILTER_CNT_W'(FILTER_CYCLES - 1);
endpackage

//--- core/gfc_glitch_filter.sv
// Purpose: Passes a synchronised level only after it has stood still for a few cycles.
// Assumes: The input is already synchronised to clk.
// Notes:   Adds FILTER_CYCLES of latency to every accepted transition.
`timescale 1ns/1ns
module gfc_glitch_filter (
    // Clock and reset.
    input  wire logic clk,
    input  wire logic rstn,
    // Level in and filtered level out.
    input  wire logic level_in,
    output logic      level_out
);
    import gfc_pkg::*;

    logic [FILTER_CNT_W-1:0] cnt_q;
    logic                    out_q;
    wire                     differs = level_in != out_q;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cnt_q <= '0;
            out_q <= 1'b1;
        end else if (!differs) begin
            cnt_q <= '0;
        end else if (cnt_q == FILTER_LAST) begin
            cnt_q <= '0;
            out_q <= level_in;
        end else begin
            cnt_q <= cnt_q + 1'b1;
        end
    end

    assign level_out = out_q;
endmodule

//--- core/gfc_top.sv
// Purpose: Multifunction pin control and comparator status register of a quad-channel converter.
// Assumes: Pin, comparator and window inputs are asynchronous; busy and protect inputs share clk.
// Notes:   Register reads return data one cycle after the read strobe.
`timescale 1ns/1ns
// Operation
// - Protect flag set while active, cleared by read
// - Window results latched or live per setting
// - Synchronized comparator outputs, status read-only
// - Optional glitch filter on pin input
// - Drive pin only when output enabled
// - Source field selects mirrored busy/window bit
// - Channel mask enables per-channel functions
// - Function field selects global or channel action
// - Falling edge starts global fault snapshot
// - Edges power current outputs down/up
// - Edges power voltage outputs down/up
// - Clear asserted while pin is low
// - Falling edge loads codes on synced channels
// - Falling stops, rising starts waveform generation
// - Falling margin-low, rising margin-high
// - Falling enters reset, rising releases it
// - Reset selection lost unless stored nonvolatile
// - Falling permits, rising blocks nonvolatile programming
// - Rising locks register map, falling unlocks
// - Accept pin input only when enabled
// - Clear bit resets latched compare results
// - Busy bit mirrors channel refusing commands
module gfc_top (
    // Clock and reset.
    input  wire logic                          clk,
    input  wire logic                          rstn,
    // Register port.
    input  wire logic [7:0]                    reg_addr,
    input  wire logic [15:0]                   reg_wdata,
    input  wire logic                          reg_wr,
    input  wire logic                          reg_rd,
    output logic [15:0]                        reg_rdata,
    // Multifunction pin.
    input  wire logic                          pin_i,
    output logic                               pin_o,
    output logic                               pin_oe,
    // Comparator and channel status.
    input  wire logic [gfc_pkg::NUM_CH-1:0]    compare_raw,
    input  wire logic [gfc_pkg::NUM_CH-1:0]    window_raw,
    input  wire logic                          window_latch_on,
    input  wire logic [gfc_pkg::NUM_CH-1:0]    channel_busy,
    input  wire logic                          nonvolatile_in_progress,
    input  wire logic                          protect_active,
    // Per-channel settings held elsewhere.
    input  wire logic [gfc_pkg::NUM_CH-1:0]    channel_sync_select,
    input  wire logic [2*gfc_pkg::NUM_CH-1:0]  voltage_powerdown_load,
    // Nonvolatile image of the configuration.
    input  wire logic                          nv_reload,
    input  wire logic                          nv_reset_stored,
    input  wire logic [15:0]                   nv_pin_config,
    // Actions.
    output logic                               fault_snapshot,
    output logic [gfc_pkg::NUM_CH-1:0]         current_output_pdn,
    output logic [gfc_pkg::NUM_CH-1:0]         voltage_output_pdn,
    output logic [2*gfc_pkg::NUM_CH-1:0]       voltage_pdn_load,
    output logic                               output_clear,
    output logic [gfc_pkg::NUM_CH-1:0]         load_pending_codes,
    output logic [gfc_pkg::NUM_CH-1:0]         waveform_start,
    output logic [gfc_pkg::NUM_CH-1:0]         waveform_stop,
    output logic [gfc_pkg::NUM_CH-1:0]         margin_low,
    output logic [gfc_pkg::NUM_CH-1:0]         margin_high,
    output logic                               device_reset,
    output logic                               nv_write_permit,
    output logic                               reg_map_locked
);
    import gfc_pkg::*;

    localparam int SYNC_W = 1 + 2 * NUM_CH;

    // Returns the output-source code's selected bit, zero for unassigned codes.
    function automatic logic pick_source(input logic [3:0] src, input logic nvb,
                                         input logic [NUM_CH-1:0] busy, input logic [NUM_CH-1:0] win);
        logic r;
        r = 1'b0;
        if (src == SRC_NV_BUSY) begin
            r = nvb;
        end else if (src[3:2] == SRC_GRP_BUSY) begin
            r = busy[src[1:0]];
        end else if (src[3:2] == SRC_GRP_WIN) begin
            r = win[src[1:0]];
        end
        return r;
    endfunction

    // Two-stage synchroniser for all asynchronous inputs.
    logic [SYNC_W-1:0] sync1_q;
    logic [SYNC_W-1:0] sync2_q;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sync1_q <= {1'b1, {(2*NUM_CH){1'b0}}};
            sync2_q <= {1'b1, {(2*NUM_CH){1'b0}}};
        end else begin
            sync1_q <= {pin_i, window_raw, compare_raw};
            sync2_q <= sync1_q;
        end
    end

    wire                pin_sync    = sync2_q[SYNC_W-1];
    wire [NUM_CH-1:0]   win_sync    = sync2_q[2*NUM_CH-1:NUM_CH];
    wire [NUM_CH-1:0]   cmp_sync    = sync2_q[NUM_CH-1:0];

    // Register state.
    logic [15:0]        cfg_q;
    logic [15:0]        cfg_d;
    logic               protect_q;
    logic [NUM_CH-1:0]  win_q;
    logic [NUM_CH-1:0]  cmp_q;
    logic [15:0]        rdata_q;

    wire                filter_on   = cfg_q[CFG_FILTER_BIT];
    wire                out_on      = cfg_q[CFG_OUT_ON_BIT];
    wire [3:0]          out_src     = cfg_q[CFG_SRC_LSB +: 4];
    wire [NUM_CH-1:0]   ch_mask     = cfg_q[CFG_MASK_LSB +: NUM_CH];
    wire [3:0]          in_func     = cfg_q[CFG_FUNC_LSB +: 4];
    wire                in_on       = cfg_q[CFG_IN_ON_BIT];

    // Pin level after the optional filter, then edge events.
    logic pin_filt;
    gfc_glitch_filter u_filter (
        .clk       (clk),
        .rstn      (rstn),
        .level_in  (pin_sync),
        .level_out (pin_filt)
    );

    logic pin_prev_q;
    wire  pin_level = filter_on ? pin_filt : pin_sync;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pin_prev_q <= 1'b1;
        end else begin
            pin_prev_q <= pin_level;
        end
    end

    wire pin_rise = in_on & pin_level & ~pin_prev_q;
    wire pin_fall = in_on & ~pin_level & pin_prev_q;
    wire pin_low  = in_on & ~pin_level;

    // Function decode; unassigned codes match nothing.
    wire fn_snap   = in_func == FN_FAULT_SNAPSHOT;
    wire fn_ipdn   = in_func == FN_CURRENT_PDN;
    wire fn_vpdn   = in_func == FN_VOLTAGE_PDN;
    wire fn_clr    = in_func == FN_CLEAR;
    wire fn_load   = in_func == FN_LOAD_CODES;
    wire fn_wave   = in_func == FN_WAVEFORM;
    wire fn_margin = in_func == FN_MARGIN;
    wire fn_reset  = in_func == FN_DEVICE_RESET;
    wire fn_nvprot = in_func == FN_NV_PROTECT;
    wire fn_lock   = in_func == FN_REG_LOCK;

    wire [NUM_CH-1:0] ch_fall = {NUM_CH{pin_fall}} & ch_mask;
    wire [NUM_CH-1:0] ch_rise = {NUM_CH{pin_rise}} & ch_mask;

    // Register port decode.
    logic locked_q;
    wire  wr_cfg     = reg_wr & ~locked_q & (reg_addr == ADDR_PIN_CONFIG);
    wire  wr_trig    = reg_wr & ~locked_q & (reg_addr == ADDR_TRIGGER);
    wire  rd_stat    = reg_rd & (reg_addr == ADDR_COMPARE_STAT);
    wire  rd_cfg     = reg_rd & (reg_addr == ADDR_PIN_CONFIG);
    wire  reset_exit = fn_reset & pin_rise & device_reset;

    logic [NUM_CH-1:0] cmp_clear;
    genvar g;
    generate
        for (g = 0; g < NUM_CH; g++) begin : g_clr
            assign cmp_clear[g] = wr_trig & reg_wdata[TRIG_CLEAR_CH0_BIT - g*TRIG_CH_STRIDE];
        end
    endgenerate

    // Leaving a pin reset keeps the configuration only if it was stored.
    always_comb begin
        cfg_d = cfg_q;
        if (nv_reload) begin
            cfg_d = nv_pin_config & PIN_CONFIG_MASK;
        end else if (reset_exit) begin
            cfg_d = nv_reset_stored ? (nv_pin_config & PIN_CONFIG_MASK) : PIN_CONFIG_RESET;
        end else if (wr_cfg) begin
            cfg_d = reg_wdata & PIN_CONFIG_MASK;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cfg_q <= PIN_CONFIG_RESET;
        end else begin
            cfg_q <= cfg_d;
        end
    end

    // Protect flag: a set in the read cycle survives the clear.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            protect_q <= 1'b0;
        end else if (protect_active) begin
            protect_q <= 1'b1;
        end else if (rd_stat) begin
            protect_q <= 1'b0;
        end
    end

    // Window results hold set bits when latching, follow live otherwise.
    generate
        for (g = 0; g < NUM_CH; g++) begin : g_win
            always_ff @(posedge clk or negedge rstn) begin
                if (!rstn) begin
                    win_q[g] <= 1'b0;
                    cmp_q[g] <= 1'b0;
                end else begin
                    cmp_q[g] <= cmp_sync[g] & ~cmp_clear[g];
                    if (!window_latch_on || cmp_clear[g]) begin
                        win_q[g] <= win_sync[g];
                    end else begin
                        win_q[g] <= win_q[g] | win_sync[g];
                    end
                end
            end
        end
    endgenerate

    wire [15:0] stat_word = {7'h00, protect_q, win_q, cmp_q};

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rdata_q <= COMPARE_STAT_RESET;
        end else if (rd_stat) begin
            rdata_q <= stat_word;
        end else if (rd_cfg) begin
            rdata_q <= cfg_q;
        end else if (reg_rd) begin
            rdata_q <= 16'h0000;
        end
    end

    // Output mode.
    wire pin_src = pick_source(out_src, nonvolatile_in_progress, channel_busy, win_q);
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pin_o  <= 1'b0;
            pin_oe <= 1'b0;
        end else begin
            pin_o  <= out_on & pin_src;
            pin_oe <= out_on;
        end
    end

    // Input actions.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            fault_snapshot     <= 1'b0;
            output_clear       <= 1'b0;
            load_pending_codes <= '0;
            waveform_start     <= '0;
            waveform_stop      <= '0;
            margin_low         <= '0;
            margin_high        <= '0;
        end else begin
            fault_snapshot     <= fn_snap & pin_fall;
            output_clear       <= fn_clr & pin_low;
            load_pending_codes <= {NUM_CH{fn_load}} & ch_fall & channel_sync_select;
            waveform_stop      <= {NUM_CH{fn_wave}} & ch_fall;
            waveform_start     <= {NUM_CH{fn_wave}} & ch_rise;
            margin_low         <= {NUM_CH{fn_margin}} & ch_fall;
            margin_high        <= {NUM_CH{fn_margin}} & ch_rise;
        end
    end

    // Level actions held between edges.
    logic [NUM_CH-1:0] ipdn_q;
    logic [NUM_CH-1:0] vpdn_q;
    logic              nvperm_q;
    logic              devrst_q;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ipdn_q   <= '0;
            vpdn_q   <= '0;
            nvperm_q <= 1'b0;
            devrst_q <= 1'b0;
            locked_q <= 1'b0;
        end else begin
            if (fn_ipdn) begin
                ipdn_q <= (ipdn_q | ch_fall) & ~ch_rise;
            end
            if (fn_vpdn) begin
                vpdn_q <= (vpdn_q | ch_fall) & ~ch_rise;
            end
            if (fn_nvprot && pin_fall) begin
                nvperm_q <= 1'b1;
            end else if (fn_nvprot && pin_rise) begin
                nvperm_q <= 1'b0;
            end
            if (fn_reset && pin_fall) begin
                devrst_q <= 1'b1;
            end else if (reset_exit) begin
                devrst_q <= 1'b0;
            end
            if (fn_lock && pin_rise) begin
                locked_q <= 1'b1;
            end else if (fn_lock && pin_fall) begin
                locked_q <= 1'b0;
            end
        end
    end

    logic [2*NUM_CH-1:0] vload_q;
    generate
        for (g = 0; g < NUM_CH; g++) begin : g_vload
            always_ff @(posedge clk or negedge rstn) begin
                if (!rstn) begin
                    vload_q[2*g +: 2] <= 2'h0;
                end else begin
                    vload_q[2*g +: 2] <= vpdn_q[g] ? voltage_powerdown_load[2*g +: 2] : 2'h0;
                end
            end
        end
    endgenerate

    assign reg_rdata          = rdata_q;
    assign current_output_pdn = ipdn_q;
    assign voltage_output_pdn = vpdn_q;
    assign voltage_pdn_load   = vload_q;
    assign nv_write_permit    = nvperm_q;
    assign device_reset       = devrst_q;
    assign reg_map_locked     = locked_q;
endmodule

//--- tb/gfc_top_chk.sv
// Purpose: Port checks of the pin function and compare status block.
// Assumes: One clock domain; the powerdown load setting stays steady during a run.
// Notes:   Pin causes are looked up three cycles back, the latency of the unfiltered pin path.
`timescale 1ns/1ns
module gfc_top_chk (
    // Clock and reset.
    input wire logic        clk,
    input wire logic        rstn,
    // Register port.
    input wire logic [7:0]  reg_addr,
    input wire logic        reg_rd,
    input wire logic [15:0] reg_rdata,
    // Pin and status.
    input wire logic        pin_i,
    input wire logic        protect_active,
    input wire logic [7:0]  voltage_powerdown_load,
    // Actions.
    input wire logic        fault_snapshot,
    input wire logic        output_clear,
    input wire logic        device_reset,
    input wire logic [3:0]  voltage_output_pdn,
    input wire logic [7:0]  voltage_pdn_load,
    input wire logic [3:0]  waveform_start,
    input wire logic [3:0]  waveform_stop,
    input wire logic [3:0]  margin_low,
    input wire logic [3:0]  margin_high
);
    import gfc_pkg::*;
    default clocking dcb @(posedge clk);
    endclocking
    default disable iff (!rstn);
    wire rd_st = reg_rd && (reg_addr == ADDR_COMPARE_STAT);
    wire rd_un = reg_rd && !(reg_addr inside {ADDR_TRIGGER, ADDR_COMPARE_STAT, ADDR_PIN_CONFIG});
    property p_prot_set; rd_st && protect_active && $past(protect_active) |=> reg_rdata[STAT_PROTECT_BIT]; endproperty
    a_prot_set: assert property (p_prot_set) else $error("protect flag missing");
    property p_prot_clr; rd_st && !protect_active ##1 !protect_active ##1 rd_st && !protect_active
        |=> !reg_rdata[STAT_PROTECT_BIT]; endproperty
    a_prot_clr: assert property (p_prot_clr) else $error("protect flag not cleared by read");
    property p_stat_rsv; rd_st |=> reg_rdata[15:9] == 7'h00; endproperty
    a_stat_rsv: assert property (p_stat_rsv) else $error("status spare bits set");
    property p_unmapped; rd_un |=> reg_rdata == 16'h0000; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_snap_pulse; fault_snapshot |=> !fault_snapshot; endproperty
    a_snap_pulse: assert property (p_snap_pulse) else $error("snapshot longer than one cycle");
    property p_snap_cause; fault_snapshot |-> !$past(pin_i, 3); endproperty
    a_snap_cause: assert property (p_snap_cause) else $error("snapshot without low pin");
    property p_clr_cause; $rose(output_clear) |-> !$past(pin_i, 3); endproperty
    a_clr_cause: assert property (p_clr_cause) else $error("clear without low pin");
    property p_rst_in; $rose(device_reset) |-> !$past(pin_i, 3); endproperty
    a_rst_in: assert property (p_rst_in) else $error("reset entered without low pin");
    property p_rst_out; $fell(device_reset) |-> $past(pin_i, 3); endproperty
    a_rst_out: assert property (p_rst_out) else $error("reset left without high pin");
    property p_excl; ((waveform_start & waveform_stop) | (margin_low & margin_high)) == 4'h0; endproperty
    a_excl: assert property (p_excl) else $error("opposite edge actions together");
    property p_vload;
        voltage_pdn_load[1:0] == ($past(voltage_output_pdn[0]) ? voltage_powerdown_load[1:0] : 2'h0); endproperty
    a_vload: assert property (p_vload) else $error("powerdown load wrong");
endmodule

//--- tb/gfc_pin_partner.sv
// Purpose: External logic on the far side of the multifunction pin.
// Assumes: The bench never drives the pin while the block drives it.
// Notes:   The wire level is resolved here and fed back to the block.
`timescale 1ns/1ns
module gfc_pin_partner (
    // Pin as seen by the block.
    input  wire logic pin_o,
    input  wire logic pin_oe,
    output logic      pin_i,
    // Level the external logic drives.
    input  wire logic drive_level
);
    assign pin_i = pin_oe ? pin_o : drive_level;
endmodule

//--- tb/gfc_top_test.sv
// Purpose: Self-checking bench of the pin function and compare status block.
// Assumes: The pin idles high; in output mode it follows the selected source while the input enable is off.
// Notes:   Pulses are gathered in a sticky vector and compared after each pin edge.
`timescale 1ns/1ns
module gfc_top_test;
    import gfc_pkg::*;
    logic        clk = 1'b0, rstn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, drv_lvl = 1'b1;
    logic        window_latch_on = 1'b0, nonvolatile_in_progress = 1'b0, protect_active = 1'b0;
    logic        nv_reload = 1'b0, nv_reset_stored = 1'b0, seen_clr = 1'b0;
    logic [7:0]  reg_addr = 8'h00, voltage_powerdown_load = 8'h00;
    logic [15:0] reg_wdata = 16'h0000, nv_pin_config = 16'h0000, cfg;
    logic [3:0]  compare_raw = 4'h0, window_raw = 4'h0, channel_busy = 4'h0, channel_sync_select = 4'h0;
    logic [3:0]  mask, fn;
    logic [20:0] seen = 21'h0;
    int          err_count = 0, check_count = 0, cycles = 0, seed = 95762;
    wire [15:0]  reg_rdata;
    wire         pin_i, pin_o, pin_oe, fault_snapshot, output_clear, device_reset, nv_write_permit, reg_map_locked;
    wire [3:0]   current_output_pdn, voltage_output_pdn, load_pending_codes, waveform_start, waveform_stop;
    wire [3:0]   margin_low, margin_high;
    wire [7:0]   voltage_pdn_load;
    wire [32:0]  acts = {output_clear, device_reset, nv_write_permit, reg_map_locked, current_output_pdn,
                         voltage_output_pdn, seen};
    logic [3:0]  fn_list [12] = '{FN_CURRENT_PDN, FN_FAULT_SNAPSHOT, FN_CURRENT_PDN, FN_VOLTAGE_PDN, FN_CLEAR,
        FN_LOAD_CODES, FN_WAVEFORM, FN_MARGIN, FN_DEVICE_RESET, FN_NV_PROTECT, 4'h5, FN_REG_LOCK};
    gfc_top DUT (.clk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .pin_i, .pin_o, .pin_oe,
        .compare_raw, .window_raw, .window_latch_on, .channel_busy, .nonvolatile_in_progress, .protect_active,
        .channel_sync_select, .voltage_powerdown_load, .nv_reload, .nv_reset_stored, .nv_pin_config,
        .fault_snapshot, .current_output_pdn, .voltage_output_pdn, .voltage_pdn_load, .output_clear,
        .load_pending_codes, .waveform_start, .waveform_stop, .margin_low, .margin_high, .device_reset,
        .nv_write_permit, .reg_map_locked);
    gfc_pin_partner u_pin (.pin_o, .pin_oe, .pin_i, .drive_level(drv_lvl));
    always #5 clk = ~clk;
    always @(posedge clk) begin
        seen <= seen_clr ? 21'h0 : seen | {fault_snapshot, load_pending_codes, waveform_start, waveform_stop,
                                           margin_low, margin_high};
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_count++;
            finish_test();
        end
    end
    task automatic tick(input int n = 1);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic chk(input logic [32:0] got, input logic [32:0] exp);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        tick();
        reg_wr = 1'b0;
        tick();
    endtask
    task automatic rdck(input logic [7:0] a, input logic [15:0] e);
        reg_addr = a;
        reg_rd = 1'b1;
        tick();
        reg_rd = 1'b0;
        tick();
        chk({17'h0, reg_rdata}, {17'h0, e});
    endtask
    function automatic logic [32:0] exp_act(input logic [3:0] f, input logic [3:0] m, input logic low);
        logic [3:0] c, v, l, ws, wp, ml, mh;
        logic       cl, dr, nv, lk, fs;
        {c, v, l, ws, wp, ml, mh, cl, dr, nv, lk, fs} = '0;
        case (f)
            FN_FAULT_SNAPSHOT: fs = low;
            FN_CURRENT_PDN:    c = low ? m : 4'h0;
            FN_VOLTAGE_PDN:    v = low ? m : 4'h0;
            FN_CLEAR:          cl = low;
            FN_LOAD_CODES:     l = low ? (m & channel_sync_select) : 4'h0;
            FN_WAVEFORM:       {wp, ws} = low ? {m, 4'h0} : {4'h0, m};
            FN_MARGIN:         {ml, mh} = low ? {m, 4'h0} : {4'h0, m};
            FN_DEVICE_RESET:   dr = low;
            FN_NV_PROTECT:     nv = low;
            FN_REG_LOCK:       lk = !low;
            default:           ;
        endcase
        return {cl, dr, nv, lk, c, v, fs, l, ws, wp, ml, mh};
    endfunction
    function automatic logic src_bit(input int c);
        if (c == 1) return nonvolatile_in_progress;
        if (c >= 4 && c <= 7) return channel_busy[c-4];
        if (c >= 8 && c <= 11) return window_raw[c-8];
        return 1'b0;
    endfunction
    task automatic pin_edge(input logic low, input logic [3:0] f);
        seen_clr = 1'b1;
        drv_lvl = !low;
        tick();
        seen_clr = 1'b0;
        tick(14);
        chk(acts, exp_act(f, mask, low));
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    initial begin
        voltage_powerdown_load = 8'($random(seed));
        channel_sync_select = 4'($random(seed));
        tick(6);
        rstn = 1'b1;
        tick();
        rdck(ADDR_COMPARE_STAT, COMPARE_STAT_RESET);
        rdck(ADDR_PIN_CONFIG, PIN_CONFIG_RESET);
        rdck(8'h30, 16'h0000);
        cfg = 16'($random(seed)) & 16'hdffe;
        wr(ADDR_PIN_CONFIG, cfg);
        rdck(ADDR_PIN_CONFIG, cfg & PIN_CONFIG_MASK);
        wr(ADDR_COMPARE_STAT, 16'hffff);
        rdck(ADDR_COMPARE_STAT, 16'h0000);
        $display("test registers done");
        for (int i = 0; i < 16; i++) begin
            wr(ADDR_PIN_CONFIG, 16'h2000 | (16'(i) << CFG_SRC_LSB));
            repeat (3) begin
                {nonvolatile_in_progress, channel_busy, window_raw} = 9'($random(seed));
                tick(6);
                chk(33'({pin_oe, pin_o}), 33'({1'b1, src_bit(i)}));
            end
        end
        wr(ADDR_PIN_CONFIG, 16'h0000);
        chk(33'(pin_oe), 33'h0);
        $display("test pin output done");
        {compare_raw, window_raw} = 8'($random(seed));
        tick(6);
        rdck(ADDR_COMPARE_STAT, {8'h00, window_raw, compare_raw});
        window_latch_on = 1'b1;
        window_raw = 4'hf;
        tick(6);
        window_raw = 4'h0;
        tick(6);
        rdck(ADDR_COMPARE_STAT, {8'h00, 4'hf, compare_raw});
        wr(ADDR_TRIGGER, 16'h8000);
        rdck(ADDR_COMPARE_STAT, {8'h00, 4'he, compare_raw});
        window_latch_on = 1'b0;
        protect_active = 1'b1;
        tick(2);
        rdck(ADDR_COMPARE_STAT, {7'h00, 1'b1, 4'h0, compare_raw});
        protect_active = 1'b0;
        rdck(ADDR_COMPARE_STAT, {7'h00, 1'b1, 4'h0, compare_raw});
        rdck(ADDR_COMPARE_STAT, {7'h00, 1'b0, 4'h0, compare_raw});
        $display("test status done");
        for (int k = 0; k < 12; k++) begin
            mask = 4'($random(seed)) | 4'h1;
            fn = fn_list[k];
            cfg = {k[0], 6'h00, mask, fn, k != 0};
            wr(ADDR_PIN_CONFIG, cfg);
            pin_edge(1'b1, (k != 0) ? fn : 4'h0);
            pin_edge(1'b0, (k != 0) ? fn : 4'h0);
            if (fn == FN_DEVICE_RESET) begin
                rdck(ADDR_PIN_CONFIG, 16'h0000);
                wr(ADDR_PIN_CONFIG, cfg);
                {nv_reset_stored, nv_pin_config} = {1'b1, cfg};
                pin_edge(1'b1, fn);
                pin_edge(1'b0, fn);
                rdck(ADDR_PIN_CONFIG, cfg & PIN_CONFIG_MASK);
            end
            if (fn == FN_REG_LOCK) begin
                wr(ADDR_PIN_CONFIG, 16'h0000);
                rdck(ADDR_PIN_CONFIG, cfg & PIN_CONFIG_MASK);
                pin_edge(1'b1, fn);
                wr(ADDR_PIN_CONFIG, 16'h0000);
                pin_edge(1'b0, 4'h0);
            end
        end
        $display("test pin functions done");
        for (int f = 0; f < 2; f++) begin
            wr(ADDR_PIN_CONFIG, {f[0], 6'h00, 4'h1, FN_FAULT_SNAPSHOT, 1'b1});
            seen_clr = 1'b1;
            drv_lvl = 1'b0;
            tick();
            seen_clr = 1'b0;
            tick();
            drv_lvl = 1'b1;
            tick(14);
            chk(33'(seen[20]), 33'(f == 0));
        end
        $display("test glitch filter done");
        nv_pin_config = 16'($random(seed)) & 16'hdffe;
        nv_reload = 1'b1;
        tick();
        nv_reload = 1'b0;
        rdck(ADDR_PIN_CONFIG, nv_pin_config & PIN_CONFIG_MASK);
        $display("test reload done");
        finish_test();
    end
endmodule
bind gfc_top gfc_top_chk u_chk (.clk, .rstn, .reg_addr, .reg_rd, .reg_rdata, .pin_i, .protect_active,
    .voltage_powerdown_load, .fault_snapshot, .output_clear, .device_reset, .voltage_output_pdn,
    .voltage_pdn_load, .waveform_start, .waveform_stop, .margin_low, .margin_high);
